/* dsp_pkg.sv */
// Package of constants and types for the debug serial and trace port
// Summary of operation
// RULE1 - Top response bit flags status, data otherwise
// RULE2 - Done without data: status 0, data FFFF
// RULE3 - Not ready: status 1, data 0000
// RULE4 - Bus error on access: status 1, data 0001
// RULE5 - Host sends zero in top bit
// RULE6 - Device ignores received top bit
// RULE7 - Pipe-advance pulses per instruction start and advance
// RULE8 - Fetch-track marks operand loads into pipeline
// RULE9 - Fetch-track also signals pipeline flushes
// RULE10 - Breakpoint accepted on any memory access
// RULE11 - Flushed prefetch breakpoints never acknowledged
// RULE12 - Operand breakpoints always acknowledged
// RULE13 - Acknowledge goes to vector 12 or debug mode
// RULE14 - Frames are seventeen bits long
// RULE15 - MSB first, change on fall, sample rise
// RULE16 - Host clocks link up to half system clock
// RULE17 - Every bit moves both directions at once
// RULE18 - Host reshifts after not-ready until real answer
package dsp_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int          FRAME_BITS  = 17;
  localparam int          DATA_BITS   = 16;
  localparam int          STATUS_POS  = 16;
  localparam logic [4:0]  LAST_BIT    = 5'h10;

  // ----------------------------------------------------------------
  // Response patterns and breakpoint vector
  // ----------------------------------------------------------------
  localparam logic [15:0] DATA_ALL_ONE  = 16'hFFFF;
  localparam logic [15:0] DATA_NOT_RDY  = 16'h0000;
  localparam logic [15:0] DATA_BUS_ERR  = 16'h0001;
  localparam logic [7:0]  BREAKPOINT_REQUEST_INPUT_VECTOR   = 8'h0C;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [16:0] RESP_RST      = 17'h10000;

  // Response kinds offered by the core
  typedef enum logic [2:0] {
    DSP_RESP_DATA,
    DSP_RESP_DONE,
    DSP_RESP_NOT_READY,
    DSP_RESP_BUS_ERROR,
    DSP_RESP_ILLEGAL
  } dsp_resp_t;

  // Breakpoint tracker states
  typedef enum logic [1:0] {
    DSP_BK_IDLE,
    DSP_BK_PENDING,
    DSP_BK_ACK
  } dsp_bk_t;

endpackage

/* dsp_serial_link.sv */
// Link-clock shift register for the seventeen-bit full-duplex frame
`timescale 1ns/1ps
`default_nettype none
module dsp_serial_link (
  // Link side
  input  wire logic        debug_serial_clock_i,
  input  wire logic        link_rst_i,
  input  wire logic        debug_serial_in_i,
  output logic             debug_serial_out_o,
  // Parallel side, link domain
  input  wire logic [16:0] load_word_i,
  input  wire logic        load_tog_i,
  output logic [15:0]      rx_word_o,
  output logic             rx_tog_o
);

  // ----------------------------------------------------------------
  // Shift logic
  // ----------------------------------------------------------------
  logic [16:0] rx_shift;
  logic [16:0] tx_shift;
  logic [4:0]  bit_cnt;

  // Sample on rising edge, MSB first
  always_ff @(posedge debug_serial_clock_i) begin
    if (link_rst_i) begin
      rx_shift  <= 17'h00000;
      bit_cnt   <= 5'h00;
      rx_word_o <= 16'h0000;
      rx_tog_o  <= 1'b0;
    end else begin
      rx_shift <= {rx_shift[15:0], debug_serial_in_i}; // RULE15 RULE17
      if (bit_cnt == dsp_pkg::LAST_BIT) begin // RULE14
        bit_cnt   <= 5'h00;
        // Last bit joins as it arrives; the status bit falls off the top
        rx_word_o <= {rx_shift[14:0], debug_serial_in_i}; // RULE6
        rx_tog_o  <= ~rx_tog_o;
      end else begin
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end

  // Change out data on falling edge; reload at frame boundary
  always_ff @(negedge debug_serial_clock_i) begin
    if (link_rst_i) begin
      tx_shift <= dsp_pkg::RESP_RST;
    end else if (bit_cnt == 5'h00) begin
      tx_shift <= load_word_i; // RULE15
    end else begin
      tx_shift <= {tx_shift[15:0], 1'b0};
    end
  end

  // The word handed over may move only together with its toggle
  a_load_paired: assert property (@(posedge debug_serial_clock_i) disable iff (link_rst_i) // RULE14
    $changed(load_word_i) |-> $changed(load_tog_i))
    else $error("frame word changed without toggle");

  assign debug_serial_out_o = tx_shift[16]; // RULE17

endmodule
`default_nettype wire

/* dsp_top.sv */
// Debug serial port, response encoder, pipeline tracking and breakpoint steering
`timescale 1ns/1ps
`default_nettype none
module dsp_top (
  // System clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // Serial link
  input  wire logic        debug_serial_clock_i,
  input  wire logic        debug_serial_in_i,
  output logic             debug_serial_out_o,
  // Core response port
  input  wire logic        resp_valid_i,
  input  wire logic [2:0]  resp_kind_i,
  input  wire logic [15:0] resp_data_i,
  output logic [15:0]      cmd_word_o,
  output logic             cmd_valid_o,
  // Pipeline events
  input  wire logic        instr_start_i,
  input  wire logic        mid_advance_i,
  input  wire logic        operand_load_i,
  input  wire logic        pipe_flush_i,
  output logic             pipe_advance_out_o,
  output logic             fetch_track_out_o,
  // Breakpoints
  input  wire logic        breakpoint_request_input_i,
  input  wire logic        int_breakpoint_request_input_i,
  input  wire logic        mem_cycle_i,
  input  wire logic        cycle_is_prefetch_i,
  input  wire logic        cycle_end_i,
  input  wire logic        prefetch_used_i,
  input  wire logic        background_debug_mode_en_i,
  output logic             breakpoint_request_input_exception_o,
  output logic [7:0]       breakpoint_request_input_vector_o,
  output logic             background_debug_mode_o
);

  // ----------------------------------------------------------------
  // Link reset: system reset brought into the link domain
  // ----------------------------------------------------------------
  logic link_rst_s1;
  logic link_rst;

  // Reset reaches link only while the host clocks
  always_ff @(posedge debug_serial_clock_i) begin
    link_rst_s1 <= rst_i;
    link_rst    <= link_rst_s1;
  end

  // ----------------------------------------------------------------
  // Response encoding, system domain
  // ----------------------------------------------------------------
  logic [16:0] next_resp;
  logic [16:0] resp_word;
  logic        resp_tog;

  // Map response kinds onto status bit and data pattern
  function automatic logic [16:0] encode_resp(input logic [2:0] kind, input logic [15:0] data);
    logic [16:0] w;
    w = {1'b1, dsp_pkg::DATA_ALL_ONE}; // RULE1
    case (dsp_pkg::dsp_resp_t'(kind))
      dsp_pkg::DSP_RESP_DATA:      w = {1'b0, data}; // RULE1
      dsp_pkg::DSP_RESP_DONE:      w = {1'b0, dsp_pkg::DATA_ALL_ONE}; // RULE2
      dsp_pkg::DSP_RESP_NOT_READY: w = {1'b1, dsp_pkg::DATA_NOT_RDY}; // RULE3
      dsp_pkg::DSP_RESP_BUS_ERROR: w = {1'b1, dsp_pkg::DATA_BUS_ERR}; // RULE4
      dsp_pkg::DSP_RESP_ILLEGAL:   w = {1'b1, dsp_pkg::DATA_ALL_ONE}; // RULE1
      default:                     w = {1'b1, dsp_pkg::DATA_ALL_ONE};
    endcase
    return w;
  endfunction

  assign next_resp = resp_valid_i ? encode_resp(resp_kind_i, resp_data_i) : resp_word;

  // Response holds until replaced; default answer is not-ready
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      resp_word <= {1'b1, dsp_pkg::DATA_NOT_RDY}; // RULE3
      resp_tog  <= 1'b0;
    end else begin
      resp_word <= next_resp;
      if (resp_valid_i)
        resp_tog <= ~resp_tog;
    end
  end

  // ----------------------------------------------------------------
  // Crossing of the response word into the link domain
  // ----------------------------------------------------------------
  logic        rtog_s1;
  logic        rtog_s2;
  logic        rtog_s3;
  logic [16:0] link_resp;

  // Word is stable when toggle arrives, so it is sampled after sync
  // Only the second and third stages are compared; the first may be metastable
  always_ff @(posedge debug_serial_clock_i) begin
    if (link_rst) begin
      rtog_s1   <= 1'b0;
      rtog_s2   <= 1'b0;
      rtog_s3   <= 1'b0;
      link_resp <= {1'b1, dsp_pkg::DATA_NOT_RDY};
    end else begin
      rtog_s1 <= resp_tog;
      rtog_s2 <= rtog_s1;
      rtog_s3 <= rtog_s2;
      if (rtog_s3 != rtog_s2)
        link_resp <= resp_word;
    end
  end

  // ----------------------------------------------------------------
  // Serial shifter
  // ----------------------------------------------------------------
  logic [15:0] link_rx_word;
  logic        link_rx_tog;

  dsp_serial_link u_link (
    .debug_serial_clock_i (debug_serial_clock_i),
    .link_rst_i           (link_rst),
    .debug_serial_in_i    (debug_serial_in_i),
    .debug_serial_out_o   (debug_serial_out_o),
    .load_word_i          (link_resp),
    .load_tog_i           (rtog_s3),
    .rx_word_o            (link_rx_word),
    .rx_tog_o             (link_rx_tog)
  );

  // ----------------------------------------------------------------
  // Crossing of received command word into system domain
  // ----------------------------------------------------------------
  logic ctog_s1;
  logic ctog_s2;
  logic ctog_s3;

  // Toggle sync, data captured after the toggle settles
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctog_s1     <= 1'b0;
      ctog_s2     <= 1'b0;
      ctog_s3     <= 1'b0;
      cmd_word_o  <= 16'h0000;
      cmd_valid_o <= 1'b0;
    end else begin
      ctog_s1     <= link_rx_tog;
      ctog_s2     <= ctog_s1;
      ctog_s3     <= ctog_s2;
      cmd_valid_o <= ctog_s3 != ctog_s2;
      if (ctog_s3 != ctog_s2)
        cmd_word_o <= link_rx_word; // RULE6
    end
  end

  // ----------------------------------------------------------------
  // Pipeline tracking outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pipe_advance_out_o <= 1'b0;
      fetch_track_out_o  <= 1'b0;
    end else begin
      pipe_advance_out_o <= instr_start_i | mid_advance_i; // RULE7
      fetch_track_out_o  <= operand_load_i | pipe_flush_i; // RULE8 RULE9
    end
  end

  // ----------------------------------------------------------------
  // Breakpoint steering
  // ----------------------------------------------------------------
  dsp_pkg::dsp_bk_t bk_state;
  dsp_pkg::dsp_bk_t next_bk_state;
  wire bk_req     = (breakpoint_request_input_i | int_breakpoint_request_input_i) & mem_cycle_i; // RULE10
  wire bk_operand = bk_req & ~cycle_is_prefetch_i;
  wire bk_fetch   = bk_req & cycle_is_prefetch_i;
  wire bk_fire    = bk_operand | ((bk_state == dsp_pkg::DSP_BK_PENDING) & prefetch_used_i);

  // Prefetch breakpoints wait until the word is used or flushed
  always_comb begin
    next_bk_state = bk_state;
    case (bk_state)
      dsp_pkg::DSP_BK_IDLE:
        if (bk_operand)
          next_bk_state = dsp_pkg::DSP_BK_ACK; // RULE12
        else if (bk_fetch & cycle_end_i)
          next_bk_state = dsp_pkg::DSP_BK_PENDING;
      dsp_pkg::DSP_BK_PENDING:
        if (bk_operand | prefetch_used_i)
          next_bk_state = dsp_pkg::DSP_BK_ACK;
        else if (pipe_flush_i)
          next_bk_state = dsp_pkg::DSP_BK_IDLE; // RULE11
      dsp_pkg::DSP_BK_ACK:
        next_bk_state = dsp_pkg::DSP_BK_IDLE;
      default:
        next_bk_state = dsp_pkg::DSP_BK_IDLE;
    endcase
  end

  // Acknowledge goes to exception or to debug mode
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      bk_state                <= dsp_pkg::DSP_BK_IDLE;
      breakpoint_request_input_exception_o        <= 1'b0;
      background_debug_mode_o <= 1'b0;
      breakpoint_request_input_vector_o           <= 8'h00;
    end else begin
      bk_state                <= next_bk_state;
      breakpoint_request_input_exception_o        <= bk_fire & ~background_debug_mode_en_i; // RULE13
      background_debug_mode_o <= bk_fire & background_debug_mode_en_i; // RULE13
      breakpoint_request_input_vector_o           <= dsp_pkg::BREAKPOINT_REQUEST_INPUT_VECTOR;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_pipe_adv_pulse: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE7
    (instr_start_i | mid_advance_i) |=> pipe_advance_out_o)
    else $error("pipe advance missed");
  a_fetch_flush: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE9
    pipe_flush_i |=> fetch_track_out_o)
    else $error("flush not signalled");
  a_fetch_load: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE8
    operand_load_i |=> fetch_track_out_o)
    else $error("operand load not signalled");
  a_operand_ack: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE12
    bk_operand |=> (breakpoint_request_input_exception_o | background_debug_mode_o))
    else $error("operand breakpoint lost");
  a_flush_noack: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE11
    (bk_state == dsp_pkg::DSP_BK_PENDING && pipe_flush_i && !prefetch_used_i && !bk_operand)
      |=> !breakpoint_request_input_exception_o && !background_debug_mode_o)
    else $error("flushed breakpoint acknowledged");
  a_ack_route: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE13
    !(breakpoint_request_input_exception_o && background_debug_mode_o) && (breakpoint_request_input_exception_o -> breakpoint_request_input_vector_o == 8'h0C))
    else $error("breakpoint routed twice");
  a_not_ready: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE3
    (resp_valid_i && resp_kind_i == 3'(dsp_pkg::DSP_RESP_NOT_READY)) |=> resp_word == 17'h10000)
    else $error("not ready encoding wrong");
  a_bus_error: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE4
    (resp_valid_i && resp_kind_i == 3'(dsp_pkg::DSP_RESP_BUS_ERROR)) |=> resp_word == 17'h10001)
    else $error("bus error encoding wrong");
  a_done_ok: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE2
    (resp_valid_i && resp_kind_i == 3'(dsp_pkg::DSP_RESP_DONE)) |=> resp_word == 17'h0FFFF)
    else $error("complete encoding wrong");
  a_data_valid: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE1
    (resp_valid_i && resp_kind_i == 3'(dsp_pkg::DSP_RESP_DATA))
      |=> resp_word == {1'b0, $past(resp_data_i)})
    else $error("data encoding wrong");
  a_cmd_pulse: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE14
    cmd_valid_o |=> !cmd_valid_o)
    else $error("command strobe too long");
  a_cmd_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE6
    !cmd_valid_o |-> $stable(cmd_word_o))
    else $error("command word moved without strobe");
  a_illegal_cmd: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE1
    (resp_valid_i && resp_kind_i > 3'(dsp_pkg::DSP_RESP_BUS_ERROR)) |=> resp_word == 17'h1FFFF)
    else $error("illegal encoding wrong");
  a_resp_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE3
    !resp_valid_i |=> $stable(resp_word))
    else $error("response moved without request");
  a_pipe_quiet: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE7
    !(instr_start_i || mid_advance_i) |=> !pipe_advance_out_o)
    else $error("pipe advance without event");
  a_fetch_quiet: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE8 RULE9
    !(operand_load_i || pipe_flush_i) |=> !fetch_track_out_o)
    else $error("fetch track without event");

  // ----------------------------------------------------------------
  // Multi-step breakpoint checks
  // ----------------------------------------------------------------
  // A prefetch breakpoint parks at the end of its bus cycle
  sequence s_fetch_parked;
    bk_state == dsp_pkg::DSP_BK_IDLE && bk_fetch && cycle_end_i;
  endsequence

  // The parked word reaches execution
  sequence s_word_used;
    prefetch_used_i;
  endsequence

  // The parked word is thrown away before it is used
  sequence s_word_flushed;
    pipe_flush_i && !prefetch_used_i && !bk_operand;
  endsequence

  // Used words must fire, flushed ones must vanish without a trace
  a_fetch_park: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE10
    s_fetch_parked |=> bk_state == dsp_pkg::DSP_BK_PENDING)
    else $error("prefetch breakpoint not parked");
  a_used_ack: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE10
    s_fetch_parked ##1 s_word_used |=> (breakpoint_request_input_exception_o | background_debug_mode_o))
    else $error("used prefetch breakpoint lost");
  a_flush_drop: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE11
    s_fetch_parked ##1 s_word_flushed
      |=> bk_state == dsp_pkg::DSP_BK_IDLE && !breakpoint_request_input_exception_o && !background_debug_mode_o)
    else $error("flushed prefetch breakpoint kept");

  // Routing follows the enable sampled with the acknowledge
  a_route_bdm: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE13
    (bk_fire && background_debug_mode_en_i) |=> background_debug_mode_o && !breakpoint_request_input_exception_o)
    else $error("debug mode route wrong");
  a_route_exc: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE13
    (bk_fire && !background_debug_mode_en_i) |=> breakpoint_request_input_exception_o && !background_debug_mode_o)
    else $error("exception route wrong");

endmodule
`default_nettype wire

/* dsp_host_model.sv */
// Host-side serial master model for the debug link
`timescale 1ns/1ps
`default_nettype none
module dsp_host_model (
  // Link pins
  output logic      link_clk_o,
  output logic      host_data_o,
  input  wire logic dev_data_i
);
  // Clock idles low, so no stray edge reaches the device between frames
  initial begin
    link_clk_o  = 1'h0;
    host_data_o = 1'h0;
  end

  // ----------------------------------------------------------------
  // Bare clock pulses, only used around device reset
  // ----------------------------------------------------------------
  task automatic kick(input int n);
    repeat (n) begin
      #15 link_clk_o = 1'h1;
      #15 link_clk_o = 1'h0;
    end
  endtask

  // ----------------------------------------------------------------
  // One full-duplex frame, top bit first
  // ----------------------------------------------------------------
  task automatic frame(input logic [16:0] tx, output logic [16:0] rx);
    for (int i = 16; i >= 0; i--) begin
      host_data_o = tx[i];
      #15 link_clk_o = 1'h1;
      rx[i] = dev_data_i;
      #15 link_clk_o = 1'h0;
    end
    host_data_o = ~tx[0]; // Released line shows no stale value
  endtask
endmodule
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the debug serial and trace port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk, rst, lclk, hdat, ddat, rv, cv, ist, madv, opl, pfl, pa, ft;
  logic        bex, bin, mem, ipf, cend, pused, ben, bexc, background_debug_mode;
  logic [2:0]  rk;
  logic [15:0] rd, cw, last_cmd;
  logic [7:0]  bvec;
  int          fails = 0, checked = 0, n_cmd = 0, n_exc = 0, n_bdm = 0, cycles = 0;

  // ----------------------------------------------------------------
  // Design, host model and clock
  // ----------------------------------------------------------------
  dsp_top i_dut (
    .sys_clk_i(clk), .rst_i(rst), .debug_serial_clock_i(lclk), .debug_serial_in_i(hdat),
    .debug_serial_out_o(ddat), .resp_valid_i(rv), .resp_kind_i(rk), .resp_data_i(rd),
    .cmd_word_o(cw), .cmd_valid_o(cv), .instr_start_i(ist), .mid_advance_i(madv),
    .operand_load_i(opl), .pipe_flush_i(pfl), .pipe_advance_out_o(pa), .fetch_track_out_o(ft),
    .breakpoint_request_input_i(bex), .int_breakpoint_request_input_i(bin), .mem_cycle_i(mem),
    .cycle_is_prefetch_i(ipf), .cycle_end_i(cend), .prefetch_used_i(pused),
    .background_debug_mode_en_i(ben), .breakpoint_request_input_exception_o(bexc), .breakpoint_request_input_vector_o(bvec),
    .background_debug_mode_o(background_debug_mode)
  );
  dsp_host_model i_host (.link_clk_o(lclk), .host_data_o(hdat), .dev_data_i(ddat));

  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  // Event counters and hang guard; falling edge sees settled outputs
  always @(negedge clk) begin
    cycles++;
    n_exc += (bexc === 1'h1);
    n_bdm += (background_debug_mode === 1'h1);
    if (cv === 1'h1) begin
      n_cmd++;
      last_cmd = cw;
    end
    if (cycles > 20000) begin
      fails++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("Counts: %0d checked, %0d failed", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Expected frame for each response kind
  function automatic logic [16:0] exp_resp(input logic [2:0] k, input logic [15:0] d);
    case (k)
      3'h0: return {1'h0, d};
      3'h1: return {1'h0, dsp_pkg::DATA_ALL_ONE};
      3'h2: return {1'h1, dsp_pkg::DATA_NOT_RDY};
      3'h3: return {1'h1, dsp_pkg::DATA_BUS_ERR};
      default: return {1'h1, dsp_pkg::DATA_ALL_ONE};
    endcase
  endfunction

  // One frame; the received low half must come out once, unchanged
  task automatic xfer(input logic [16:0] tx, output logic [16:0] rx);
    int n0;
    n0 = n_cmd;
    i_host.frame(tx, rx);
    for (int i = 0; i < 20 && n_cmd == n0; i++) @(negedge clk);
    check("cmd_count", n_cmd - n0, 1);
    check("cmd_word", last_cmd, tx[15:0]);
  endtask

  // Breakpoint case: c = {ext, int, prefetch, dbg_en, used, flush}
  task automatic breakpoint_request_input(input logic [5:0] c, input int exp);
    int e0;
    int b0;
    e0 = n_exc;
    b0 = n_bdm;
    @(negedge clk);
    {bex, bin, ipf, ben} = c[5:2];
    mem = 1'h1;
    cend = c[3];
    @(negedge clk);
    {bex, bin, mem, cend, ipf} = '0;
    pused = c[1];
    pfl = c[0];
    @(negedge clk);
    {pused, pfl} = '0;
    repeat (6) @(negedge clk);
    check("exc_acks", n_exc - e0, ben ? 0 : exp);
    check("bdm_acks", n_bdm - b0, ben ? exp : 0);
    ben = 1'h0;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [16:0] rx;
    logic [15:0] d;
    logic [3:0]  p;
    {rv, rk, rd, ist, madv, opl, pfl, bex, bin, mem, ipf, cend, pused, ben} = '0;
    rst = 1'h1;
    d = 16'($urandom(32'h3F9A));
    fork
      i_host.kick(3);
    join_none
    repeat (16) @(negedge clk);
    rst = 1'h0;
    @(negedge clk);
    check("vector", bvec, dsp_pkg::BREAKPOINT_REQUEST_INPUT_VECTOR);
    // Two edges clear the link reset pipe; a third would start a frame
    i_host.kick(2);
    xfer(17'h0ABCD, rx);
    check("first_resp", rx, dsp_pkg::RESP_RST);
    // Every kind code, legal and not; odd passes set the host top bit
    for (int k = 0; k < 8; k++) begin
      d = 16'($urandom);
      @(negedge clk);
      rv = 1'h1;
      rk = k[2:0];
      rd = d;
      @(negedge clk);
      rv = 1'h0;
      xfer({1'h0, 16'($urandom)}, rx);
      xfer({k[0], 16'($urandom)}, rx);
      check("response", rx, exp_resp(k[2:0], d));
    end
    // Random pipeline events, each echoed one cycle later
    for (int i = 0; i < 200; i++) begin
      p = 4'($urandom);
      {ist, madv, opl, pfl} = p;
      @(negedge clk);
      check("pipe_advance", pa, p[3] | p[2]);
      check("fetch_track", ft, p[1] | p[0]);
    end
    {ist, madv, opl, pfl} = '0;
    breakpoint_request_input(6'h20, 1);
    breakpoint_request_input(6'h14, 1);
    breakpoint_request_input(6'h21, 1);
    breakpoint_request_input(6'h2A, 1);
    breakpoint_request_input(6'h19, 0);
    breakpoint_request_input(6'h2D, 0);
    close_out();
  end
endmodule
`default_nettype wire
